// [core/mci_pkg.sv]
// Constants, types and register map for the per-core interrupt enable block
//
// Functional notes
// RULE1: Three interrupt cores 0-2, each with own rx, tx and misc enables.
// RULE2: Rx enable bits 7..0 map channels 7..0; one lets channel raise rx pulse.
// RULE3: Rx channel with enable bit zero never causes the core rx pulse.
// RULE4: Tx enable bits 7..0 map channels 7..0; one lets channel raise tx pulse.
// RULE5: Tx channel with enable bit zero never causes the core tx pulse.
// RULE6: Misc bit 3 lets pending statistics interrupt raise the misc pulse.
// RULE7: Misc bit 2 lets pending host error interrupt raise the misc pulse.
// RULE8: Misc bit 1 lets link change event raise the misc pulse.
// RULE9: Misc bit 0 lets user access done event raise the misc pulse.
// RULE10: Misc enable bit zero blocks its source from the misc pulse.
// RULE11: Reset clears all enables; reserved bits read zero, ignore writes.
// RULE12: Pulse is OR over sources of pending AND enable.
package mci_pkg;
	localparam int NUM_CORES = 3;
	localparam int NUM_CHAN  = 8;
	localparam int NUM_MISC  = 4;
	localparam int ADDR_W    = 8;

	localparam logic [ADDR_W-1:0] OFS_RX_EN_BASE   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_TX_EN_BASE   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_MISC_EN_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT     = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR      = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN       = 8'h38;

	localparam int MISC_USER_BIT  = 0;
	localparam int MISC_LINK_BIT  = 1;
	localparam int MISC_HOST_BIT  = 2;
	localparam int MISC_STAT_BIT  = 3;

	localparam logic [NUM_CHAN-1:0] CHAN_EN_RESET = 8'h00;
	localparam logic [NUM_MISC-1:0] MISC_EN_RESET = 4'h0;
	localparam logic [8:0]          IRQ_RESET     = 9'h000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [NUM_CHAN-1:0] rx_channel_irq_enable_bit;
		logic [NUM_CHAN-1:0] tx_channel_irq_enable_bit;
		logic [NUM_MISC-1:0] misc_enable;
	} mci_core_en_type;

	typedef struct packed {
		logic [NUM_CHAN-1:0] rx_event;
		logic [NUM_CHAN-1:0] tx_event;
		logic                statistics_pending;
		logic                host_error_pending;
		logic                link_change_event;
		logic                user_access_done_event;
	} mci_src_type;

	typedef struct packed {
		logic core_receive_irq_pulse;
		logic core_transmit_irq_pulse;
		logic core_misc_irq_pulse;
	} mci_pulse_type;
endpackage

// [core/mci_core_gate.sv]
// One interrupt core: gates sources with its enables into three pulses
`timescale 1ns/10ps
module mci_core_gate (
	input  wire logic                     core_clk,
	input  wire logic                     rst_n,
	input  wire mci_pkg::mci_core_en_type en,
	input  wire mci_pkg::mci_src_type     src,
	output mci_pkg::mci_pulse_type        pulse
);
	import mci_pkg::*;

	logic [NUM_MISC-1:0] misc_src;
	mci_pulse_type       nxt_pulse;
	mci_pulse_type       pulse_ff;

	always_comb begin
		misc_src = '0;
		misc_src[MISC_STAT_BIT] = src.statistics_pending;
		misc_src[MISC_HOST_BIT] = src.host_error_pending;
		misc_src[MISC_LINK_BIT] = src.link_change_event;
		misc_src[MISC_USER_BIT] = src.user_access_done_event;
		nxt_pulse.core_receive_irq_pulse  = |(src.rx_event & en.rx_channel_irq_enable_bit); // RULE2 RULE3 RULE12
		nxt_pulse.core_transmit_irq_pulse = |(src.tx_event & en.tx_channel_irq_enable_bit); // RULE4 RULE5 RULE12
		nxt_pulse.core_misc_irq_pulse     = |(misc_src & en.misc_enable); // RULE6 RULE7 RULE8 RULE9 RULE10 RULE12
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_ff <= '0;
		end else begin
			pulse_ff <= nxt_pulse;
		end
	end

	assign pulse = pulse_ff;
endmodule

// [core/mci_axil_slave.sv]
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/10ps
module mci_axil_slave (
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	input  wire logic [mci_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [mci_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic                            wr_stb,
	output logic [mci_pkg::ADDR_W-1:0]      wr_addr,
	output logic [31:0]                     wr_data,
	output logic [3:0]                      wr_strb,
	input  wire logic                       wr_ok,
	output logic                            rd_stb,
	output logic [mci_pkg::ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]                rd_data,
	input  wire logic                       rd_ok
);
	import mci_pkg::*;

	logic              aw_have_ff, nxt_aw_have;
	logic              w_have_ff,  nxt_w_have;
	logic [ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
	logic [31:0]       wdata_ff,   nxt_wdata;
	logic [3:0]        wstrb_ff,   nxt_wstrb;
	logic              bvalid_ff,  nxt_bvalid;
	logic [1:0]        bresp_ff,   nxt_bresp;
	logic              rvalid_ff,  nxt_rvalid;
	logic [1:0]        rresp_ff,   nxt_rresp;
	logic [31:0]       rdata_ff,   nxt_rdata;

	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

	assign wr_stb  = aw_have_ff && w_have_ff;
	assign wr_addr = awaddr_ff;
	assign wr_data = wdata_ff;
	assign wr_strb = wstrb_ff;
	assign rd_stb  = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;

	always_comb begin
		nxt_aw_have = aw_have_ff;
		nxt_w_have  = w_have_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb   = wstrb_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_rvalid  = rvalid_ff;
		nxt_rresp   = rresp_ff;
		nxt_rdata   = rdata_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_have = 1'b1;
			nxt_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_have = 1'b1;
			nxt_wdata  = s_axi_wdata;
			nxt_wstrb  = s_axi_wstrb;
		end
		if (wr_stb) begin
			nxt_aw_have = 1'b0;
			nxt_w_have  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (rd_stb) begin
			nxt_rvalid = 1'b1;
			nxt_rdata  = rd_data;
			nxt_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= RESP_OKAY;
			rdata_ff   <= 32'h00000000;
		end else begin
			aw_have_ff <= nxt_aw_have;
			w_have_ff  <= nxt_w_have;
			awaddr_ff  <= nxt_awaddr;
			wdata_ff   <= nxt_wdata;
			wstrb_ff   <= nxt_wstrb;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			rvalid_ff  <= nxt_rvalid;
			rresp_ff   <= nxt_rresp;
			rdata_ff   <= nxt_rdata;
		end
	end
endmodule

// [core/mci_irq_enables.sv]
// Top: per-core interrupt enable registers, gating and summary interrupt
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module mci_irq_enables (
	input  wire logic                                core_clk,
	input  wire logic                                reset_n,
	input  wire logic [mci_pkg::ADDR_W-1:0]          s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [31:0]                         s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	input  wire logic [mci_pkg::ADDR_W-1:0]          s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	output logic [31:0]                              s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	input  wire mci_pkg::mci_src_type                src,
	output mci_pkg::mci_pulse_type [mci_pkg::NUM_CORES-1:0] core_pulse,
	output logic                                     irq
);
	import mci_pkg::*;

	logic                rst_sync1_ff;
	logic                rst_sync2_ff;
	logic                rst_n;

	logic                wr_stb;
	logic [ADDR_W-1:0]   wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic                wr_ok;
	logic                rd_stb;
	logic [ADDR_W-1:0]   rd_addr;
	logic [31:0]         rd_data;
	logic                rd_ok;

	mci_core_en_type [NUM_CORES-1:0] en_ff;
	mci_core_en_type [NUM_CORES-1:0] nxt_en;
	logic [8:0]          irq_stat_ff;
	logic [8:0]          nxt_irq_stat;
	logic [8:0]          irq_en_ff;
	logic [8:0]          nxt_irq_en;
	logic [8:0]          irq_evt;
	logic [8:0]          irq_clr;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync1_ff <= 1'b0;
			rst_sync2_ff <= 1'b0;
		end else begin
			rst_sync1_ff <= 1'b1;
			rst_sync2_ff <= rst_sync1_ff;
		end
	end
	assign rst_n = rst_sync2_ff;

	mci_axil_slave u_bus (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_stb        (wr_stb),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (wr_ok),
		.rd_stb        (rd_stb),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	// Per-core gates
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CORES; gi++) begin : g_core
			mci_core_gate u_gate (
				.core_clk (core_clk),
				.rst_n    (rst_n),
				.en       (en_ff[gi]),
				.src      (src),
				.pulse    (core_pulse[gi])
			); // RULE1
		end
	endgenerate

	// Write decode of enable registers
	always_comb begin
		nxt_en     = en_ff;
		nxt_irq_en = irq_en_ff;
		irq_clr    = 9'h000;
		wr_ok      = 1'b0;
		if (wr_stb) begin
			for (int c = 0; c < NUM_CORES; c++) begin
				if (wr_addr == OFS_RX_EN_BASE + ADDR_W'(4 * c)) begin
					wr_ok = 1'b1;
					if (wr_strb[0]) begin
						nxt_en[c].rx_channel_irq_enable_bit = wr_data[7:0]; // RULE1 RULE2 RULE11
					end
				end
				if (wr_addr == OFS_TX_EN_BASE + ADDR_W'(4 * c)) begin
					wr_ok = 1'b1;
					if (wr_strb[0]) begin
						nxt_en[c].tx_channel_irq_enable_bit = wr_data[7:0]; // RULE1 RULE4 RULE11
					end
				end
				if (wr_addr == OFS_MISC_EN_BASE + ADDR_W'(4 * c)) begin
					wr_ok = 1'b1;
					if (wr_strb[0]) begin
						nxt_en[c].misc_enable = wr_data[3:0]; // RULE1 RULE11
					end
				end
			end
			if (wr_addr == OFS_IRQ_STAT) begin
				wr_ok = 1'b1;
			end
			if (wr_addr == OFS_IRQ_CLR) begin
				wr_ok = 1'b1;
				if (wr_strb[0]) begin
					irq_clr[7:0] = wr_data[7:0];
				end
				if (wr_strb[1]) begin
					irq_clr[8] = wr_data[8];
				end
			end
			if (wr_addr == OFS_IRQ_EN) begin
				wr_ok = 1'b1;
				if (wr_strb[0]) begin
					nxt_irq_en[7:0] = wr_data[7:0];
				end
				if (wr_strb[1]) begin
					nxt_irq_en[8] = wr_data[8];
				end
			end
		end
	end

	// Read decode; reserved bits read zero
	always_comb begin
		rd_data = 32'h00000000;
		rd_ok   = 1'b0;
		for (int c = 0; c < NUM_CORES; c++) begin
			if (rd_addr == OFS_RX_EN_BASE + ADDR_W'(4 * c)) begin
				rd_ok   = 1'b1;
				rd_data = {24'h000000, en_ff[c].rx_channel_irq_enable_bit}; // RULE11
			end
			if (rd_addr == OFS_TX_EN_BASE + ADDR_W'(4 * c)) begin
				rd_ok   = 1'b1;
				rd_data = {24'h000000, en_ff[c].tx_channel_irq_enable_bit}; // RULE11
			end
			if (rd_addr == OFS_MISC_EN_BASE + ADDR_W'(4 * c)) begin
				rd_ok   = 1'b1;
				rd_data = {28'h0000000, en_ff[c].misc_enable}; // RULE11
			end
		end
		if (rd_addr == OFS_IRQ_STAT) begin
			rd_ok   = 1'b1;
			rd_data = {23'h0, irq_stat_ff};
		end
		if (rd_addr == OFS_IRQ_CLR) begin
			rd_ok = 1'b1;
		end
		if (rd_addr == OFS_IRQ_EN) begin
			rd_ok   = 1'b1;
			rd_data = {23'h0, irq_en_ff};
		end
	end

	// Sticky events: one bit per core pulse, set beats clear
	always_comb begin
		for (int c = 0; c < NUM_CORES; c++) begin
			irq_evt[3 * c]     = core_pulse[c].core_receive_irq_pulse;
			irq_evt[3 * c + 1] = core_pulse[c].core_transmit_irq_pulse;
			irq_evt[3 * c + 2] = core_pulse[c].core_misc_irq_pulse;
		end
		nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < NUM_CORES; c++) begin
				en_ff[c].rx_channel_irq_enable_bit <= CHAN_EN_RESET; // RULE11
				en_ff[c].tx_channel_irq_enable_bit <= CHAN_EN_RESET; // RULE11
				en_ff[c].misc_enable               <= MISC_EN_RESET; // RULE11
			end
			irq_stat_ff <= IRQ_RESET;
			irq_en_ff   <= IRQ_RESET;
		end else begin
			en_ff       <= nxt_en;
			irq_stat_ff <= nxt_irq_stat;
			irq_en_ff   <= nxt_irq_en;
		end
	end

	assign irq = |(irq_stat_ff & irq_en_ff);
endmodule

// [test/mci_cpu_model.sv]
// Processor side model: counts clock cycles in which any core raises an interrupt pulse
`timescale 1ns/10ps
module mci_cpu_model (
	input  wire logic                                        core_clk,
	input  wire logic                                        reset_n,
	input  wire mci_pkg::mci_pulse_type [mci_pkg::NUM_CORES-1:0] core_pulse,
	output logic [7:0]                                       pulse_cnt
);
	import mci_pkg::*;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pulse_cnt <= 8'h00;
		end else if (|core_pulse) begin
			pulse_cnt <= pulse_cnt + 8'h01;
		end
	end
endmodule

// [test/mci_irq_enables_assertions.sv]
// Port checker for the interrupt enable block
`timescale 1ns/10ps
module mci_irq_enables_assertions (
	input wire logic                                         core_clk,
	input wire logic                                         reset_n,
	input wire logic                                         s_axi_awready,
	input wire logic                                         s_axi_wready,
	input wire logic                                         s_axi_bvalid,
	input wire logic                                         s_axi_bready,
	input wire logic                                         s_axi_arvalid,
	input wire logic                                         s_axi_arready,
	input wire logic [31:0]                                  s_axi_rdata,
	input wire logic                                         s_axi_rvalid,
	input wire logic                                         s_axi_rready,
	input wire mci_pkg::mci_src_type                         src,
	input wire mci_pkg::mci_pulse_type [mci_pkg::NUM_CORES-1:0] core_pulse,
	input wire logic                                         irq
);
	import mci_pkg::*;
	logic [2:0] rx_p;
	logic [2:0] tx_p;
	logic [2:0] ms_p;
	assign rx_p = {core_pulse[2][2], core_pulse[1][2], core_pulse[0][2]};
	assign tx_p = {core_pulse[2][1], core_pulse[1][1], core_pulse[0][1]};
	assign ms_p = {core_pulse[2][0], core_pulse[1][0], core_pulse[0][0]};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	chk_rx_needs_event: assert property (|rx_p |-> $past(|src.rx_event))
		else $error("rx pulse without rx event");
	chk_tx_needs_event: assert property (|tx_p |-> $past(|src.tx_event))
		else $error("tx pulse without tx event");
	chk_misc_needs_src: assert property (|ms_p |-> $past(|src[3:0]))
		else $error("misc pulse without misc source");
	chk_quiet_no_pulse: assert property (src == '0 |=> core_pulse == '0)
		else $error("pulse without any source");
	chk_reset_clears: assert property ($rose(reset_n) |-> (core_pulse == '0 && !irq)[*3])
		else $error("output active right after reset");
	chk_rsvd_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == '0)
		else $error("reserved read bits not zero");
	chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	chk_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response changed early");
	chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	cover property (rx_p[0]);
	cover property (ms_p[2]);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind mci_irq_enables mci_irq_enables_assertions u_chk (.core_clk, .reset_n, .s_axi_awready,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src, .core_pulse, .irq);

// [test/tb.sv]
// Self-checking bench for the interrupt enable block
`timescale 1ns/10ps
module tb;
	import mci_pkg::*;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] en;
		logic [19:0] src;
		logic [8:0]  exp;
	} mci_row_type;
	logic                               core_clk;
	logic                               reset_n;
	logic [7:0]                         s_axi_awaddr;
	logic                               s_axi_awvalid;
	logic                               s_axi_awready;
	logic [31:0]                        s_axi_wdata;
	logic                               s_axi_wvalid;
	logic                               s_axi_wready;
	logic [1:0]                         s_axi_bresp;
	logic                               s_axi_bvalid;
	logic                               s_axi_bready;
	logic [7:0]                         s_axi_araddr;
	logic                               s_axi_arvalid;
	logic                               s_axi_arready;
	logic [31:0]                        s_axi_rdata;
	logic [1:0]                         s_axi_rresp;
	logic                               s_axi_rvalid;
	logic                               s_axi_rready;
	mci_src_type                        src;
	mci_pulse_type [NUM_CORES-1:0]      core_pulse;
	logic                               irq;
	logic [7:0]                         pulse_cnt;
	int                                 errors;
	int                                 num_checks;
	int                                 i;
	mci_row_type                        rows [9] = '{
		'{8'h00, 32'h80, 20'h80000, 9'h004},
		'{8'h04, 32'h01, 20'hFE000, 9'h000},
		'{8'h18, 32'h01, 20'hFF010, 9'h080},
		'{8'h10, 32'h7F, 20'h00800, 9'h000},
		'{8'h24, 32'h08, 20'h00008, 9'h008},
		'{8'h28, 32'h04, 20'h00004, 9'h040},
		'{8'h20, 32'h02, 20'h00002, 9'h001},
		'{8'h24, 32'h01, 20'h00001, 9'h008},
		'{8'h20, 32'h0E, 20'h00001, 9'h000}
	};

	mci_irq_enables uut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src, .core_pulse, .irq);
	mci_cpu_model u_cpu (.core_clk, .reset_n, .core_pulse, .pulse_cnt);

	always #2.5 core_clk = ~core_clk;

	task automatic tally_and_finish;
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One bus transfer; the answer is sampled on the falling edge before the edge where ready meets valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] resp, output logic [31:0] q);
		logic av;
		logic dv;
		logic rv;
		logic rr;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_arvalid <= !w;
		s_axi_bready <= w;
		s_axi_rready <= !w;
		for (int n = 0; n < 40; n++) begin
			@(negedge core_clk);
			av = w ? s_axi_awvalid & s_axi_awready : s_axi_arvalid & s_axi_arready;
			dv = s_axi_wvalid & s_axi_wready;
			rv = w ? s_axi_bvalid : s_axi_rvalid;
			rr = w ? s_axi_bready : s_axi_rready;
			resp = w ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge core_clk);
			if (av) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (dv) begin
				s_axi_wvalid <= 1'b0;
			end
			if (rv && rr) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		errors++;
		tally_and_finish();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0]  resp;
		logic [31:0] q;
		xfer(1'b1, a, d, resp, q);
		chk("bresp", {30'h0, er}, {30'h0, resp});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [1:0]  resp;
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, resp, q);
		chk("rresp", {30'h0, er}, {30'h0, resp});
		chk("rdata", exp, q);
	endtask

	task automatic do_reset(input int n);
		@(posedge core_clk);
		reset_n <= 1'b0;
		repeat (n) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
	endtask

	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		src = '0;
		errors = 0;
		num_checks = 0;
		do_reset(20);
		for (i = 0; i < 9; i++) begin
			rd(8'(4 * (i % 3) + 16 * (i / 3)), 32'h0, RESP_OKAY);
		end
		for (i = 0; i < 9; i++) begin
			wr(rows[i].addr, rows[i].en, RESP_OKAY);
			@(posedge core_clk);
			src <= rows[i].src;
			@(posedge core_clk);
			src <= '0;
			#1;
			chk("core_pulse", {23'h0, rows[i].exp}, {23'h0, core_pulse});
			wr(rows[i].addr, 32'h0, RESP_OKAY);
		end
		chk("pulse_cnt", 32'h6, {24'h0, pulse_cnt});
		rd(OFS_IRQ_STAT, 32'h1A5, RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
		chk("irq", 32'h0, {31'h0, irq});
		rd(OFS_IRQ_STAT, 32'h1A4, RESP_OKAY);
		rd(8'h40, 32'h0, RESP_SLVERR);
		wr(8'h40, 32'hFFFFFFFF, RESP_SLVERR);
		wr(8'h24, 32'hFFFFFFFF, RESP_OKAY);
		rd(8'h24, 32'h0000000F, RESP_OKAY);
		wr(8'h08, 32'hFFFFFFFF, RESP_OKAY);
		rd(8'h08, 32'h000000FF, RESP_OKAY);
		wr(8'h10, 32'hFFFFFFFF, RESP_OKAY);
		rd(8'h10, 32'h000000FF, RESP_OKAY);
		do_reset(2);
		rd(8'h24, 32'h0, RESP_OKAY);
		rd(8'h08, 32'h0, RESP_OKAY);
		rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
		tally_and_finish();
	end
endmodule
